// ### design/gdfc_top.sv
// Primary-side fault, filter and halt control of a dual-channel gate driver
`timescale 1ns/100ps
module gdfc_top
   import gdfc_pkg::*;
#(
   // Timing counts default to the real-time values at 125 MHz
   parameter int unsigned POR_CYCLES = POR_CYC,
   parameter longint unsigned FAULT_CYCLES = FAULT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Controller pins
   input wire logic high_side_command,
   input wire logic low_side_command,
   input wire logic disable_request_input,
   input wire logic supply_good_input,
   // Supply monitors and secondary-side faults
   input wire logic undervoltage_trip,
   input wire logic sec_undervoltage_trip,
   input wire logic short_circuit_detect,
   input wire logic upper_external_fault_input_n,
   input wire logic lower_external_fault_input_n,
   // Outputs
   output logic high_gate_on,
   output logic low_gate_on,
   output logic not_ready_output
);
   import gdfc_pkg::*;

   // Pin count: two commands, halt, supply-good, three monitors, two faults
   localparam int NSYNC = 9;

   // Three-stage synchronisers for all pins; stage 0 feeds only stage 1
   // Every pin is asynchronous to mclk, so none is read before it has passed two stages.
   // Stages reset to the idle pin levels; a zero reset would look like a
   // supply-good drop and external faults on the first cycles after reset.
   // Latency from pin to clean level is four edges, which the trip and
   // filter budgets below already include.
   logic [NSYNC-1:0] pin_in;
   logic [NSYNC-1:0] s0_r, s1_r, s2_r, clean_r;
   assign pin_in = {high_side_command, low_side_command, disable_request_input,
                    supply_good_input, undervoltage_trip, sec_undervoltage_trip,
                    short_circuit_detect, upper_external_fault_input_n,
                    lower_external_fault_input_n};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s0_r <= PIN_IDLE;
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         clean_r <= PIN_IDLE;
      end else begin
         s0_r <= pin_in;
         s1_r <= s0_r;
         s2_r <= s1_r;
         // A change counts once stages two and three agree
         for (int i = 0; i < NSYNC; i++) begin
            if (s1_r[i] == s2_r[i]) clean_r[i] <= s2_r[i];
         end
      end
   end

   logic hs_raw, ls_raw, halt_s, sgood_s, uvp_s, uvs_s, sc_s, efu_n, efl_n;
   assign {hs_raw, ls_raw, halt_s, sgood_s, uvp_s, uvs_s, sc_s, efu_n, efl_n} = clean_r;

   // Glitch filter: a new level must hold FILT_CYC cycles before it is taken
   // The counter restarts whenever the raw level returns to the taken one,
   // so a burst of short spikes never adds up to a false edge.
   // With 87 cycles at 8 ns the cut lies near 700 ns, inside the window
   // in which either outcome is allowed; a clock above about 367 MHz would
   // need a wider counter, since 8 bits only count to 255 cycles.
   logic [1:0] cmd_raw, cmd_filt_r;
   logic [7:0] filt_cnt_r [2];
   assign cmd_raw = {hs_raw, ls_raw};  // Active high commands

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_filt_r <= 2'h0;
         filt_cnt_r[0] <= 8'h00;
         filt_cnt_r[1] <= 8'h00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (cmd_raw[c] == cmd_filt_r[c]) begin
               filt_cnt_r[c] <= 8'h00;  // Short pulse discarded
            end else if (filt_cnt_r[c] >= 8'(FILT_CYC - 1)) begin
               cmd_filt_r[c] <= cmd_raw[c];
               filt_cnt_r[c] <= 8'h00;
            end else begin
               filt_cnt_r[c] <= filt_cnt_r[c] + 8'h01;
            end
         end
      end
   end

   // Supply faults persist as levels; external faults are active low
   // Supply faults also block recovery; external faults only trip, since
   // they are not watched while not-ready is high.
   logic supply_fault, ext_fault;
   assign supply_fault = !sgood_s || uvp_s || uvs_s;
   assign ext_fault = sc_s || !efu_n || !efl_n;

   // Idle counter: both filtered commands low for more than 9 us
   // It saturates at its threshold rather than wrapping, so a long idle
   // period keeps recovery allowed instead of forgetting it.
   // The threshold sits one cycle above 9 us, so the wait is strictly longer.
   logic [11:0] idle_cnt_r;
   logic idle_ok;
   assign idle_ok = idle_cnt_r >= 12'(IDLE_CYC);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idle_cnt_r <= 12'h000;
      end else if (cmd_filt_r != 2'h0) begin
         idle_cnt_r <= 12'h000;
      end else if (!idle_ok) begin
         idle_cnt_r <= idle_cnt_r + 12'h001;
      end
   end

   // Main state machine with one shared timer for reset and fault hold
   // The power-on and fault intervals never overlap, so one 32-bit timer
   // serves both and saves a second wide counter.
   // The fault hold counts from the cycle of detection; a fault that is
   // still present when the hold ends keeps the device waiting if it is a supply fault.
   gdfc_state_t state_r;
   logic [31:0] tmr_r;
   logic tmr_done;
   assign tmr_done = (state_r == GDFC_POR) ? (tmr_r >= POR_CYCLES)
                                           : (64'(tmr_r) >= FAULT_CYCLES);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= GDFC_POR;
         tmr_r <= 32'h0000_0000;
      end else begin
         case (state_r)
            GDFC_POR: begin
               // Supply-good low restarts the power-on interval
               if (!sgood_s) begin
                  tmr_r <= 32'h0000_0000;
               end else if (!tmr_done) begin
                  tmr_r <= tmr_r + 32'h0000_0001;
               end else if (supply_fault) begin
                  // A supply fault at the end of power-on goes straight to the hold
                  state_r <= GDFC_FAULT;
                  tmr_r <= 32'h0000_0000;
               end else begin
                  state_r <= GDFC_RUN;
               end
            end
            GDFC_RUN: begin
               // External faults are only watched here, while ready
               // A fault still present at recovery is seen on the first cycle
               if (supply_fault || ext_fault) begin
                  state_r <= GDFC_FAULT;
                  tmr_r <= 32'h0000_0000;
               end
            end
            GDFC_FAULT: begin
               // Recovery waits for the hold time, clean supplies and idle inputs
               if (!tmr_done) begin
                  tmr_r <= tmr_r + 32'h0000_0001;
               end else if (!supply_fault && idle_ok) begin
                  state_r <= GDFC_RUN;
               end
            end
            default: begin
               // Illegal code: restart power-on as the safe choice
               state_r <= GDFC_POR;
               tmr_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Gate outputs pass commands only when running and not halted
   // Fault levels are checked here as well as in the state, so gates drop
   // one cycle earlier than not-ready rises and never lag it.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         high_gate_on <= 1'b0;
         low_gate_on <= 1'b0;
      end else if (state_r == GDFC_RUN && !supply_fault && !ext_fault && !halt_s) begin
         high_gate_on <= cmd_filt_r[1];
         low_gate_on <= cmd_filt_r[0];
      end else begin
         high_gate_on <= 1'b0;
         low_gate_on <= 1'b0;
      end
   end

   // Not-ready tracks state only; halt has no say in it
   // Since not-ready is looped into halt outside, a halt that fed back
   // here would lock the device in halt forever.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         not_ready_output <= 1'b1;
      end else begin
         not_ready_output <= (state_r != GDFC_RUN);
      end
   end
endmodule

// ### design/gdfc_pkg.sv
// Package with timing constants and state codes for the gate driver fault control
package gdfc_pkg;
   // Clock rate in kHz (125 MHz)
   localparam int unsigned CLK_KHZ = 125000;
   // Power-on reset time, ms
   localparam int unsigned POR_MS = 150;
   localparam int unsigned POR_CYC = POR_MS * CLK_KHZ;
   // Glitch filter: discard below 625 ns, pass above 750 ns; 700 ns threshold
   localparam int unsigned FILT_NS = 700;
   localparam int unsigned FILT_CYC = (FILT_NS * CLK_KHZ) / 1000000;
   // Fault hold time, s
   localparam int unsigned FAULT_S = 3;
   localparam longint unsigned FAULT_CYC = longint'(FAULT_S) * CLK_KHZ * 1000;
   // Idle-low time before fault clear, ns (must exceed 9 us)
   localparam int unsigned IDLE_NS = 9000;
   localparam int unsigned IDLE_CYC = (IDLE_NS * CLK_KHZ) / 1000000 + 1;
   // Idle pin levels for synchroniser reset: halt, supply-good and external fault inputs high
   localparam logic [8:0] PIN_IDLE = 9'h063;
   // Controller states
   typedef enum logic [1:0] {
      GDFC_POR = 2'b00,
      GDFC_RUN = 2'b01,
      GDFC_FAULT = 2'b10
   } gdfc_state_t;
endpackage

// ### testbench/gdfc_asserts.sv
// Port-level checks for the gate driver fault control block
`timescale 1ns/100ps
module gdfc_asserts (
   // Clock, reset and inputs
   input logic mclk, rst, high_side_command, low_side_command, disable_request_input,
   input logic supply_good_input, undervoltage_trip, sec_undervoltage_trip,
   input logic short_circuit_detect, upper_external_fault_input_n, lower_external_fault_input_n,
   // Outputs
   input logic high_gate_on, low_gate_on, not_ready_output
);
   logic [10:0] idle_r;
   wire no_fault = supply_good_input & upper_external_fault_input_n
      & lower_external_fault_input_n & ~(undervoltage_trip | sec_undervoltage_trip
      | short_circuit_detect);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Cycles with both commands low; saturates so a long idle never wraps to zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) idle_r <= 11'h000;
      else if (high_side_command | low_side_command) idle_r <= 11'h000;
      else if (idle_r != 11'h7FF) idle_r <= idle_r + 11'h001;
   end
   a_uv_trip: assert property ($rose(undervoltage_trip) |-> ##[1:8] not_ready_output)
      else $error("primary undervoltage not flagged");
   a_sec_uv_trip: assert property ($rose(sec_undervoltage_trip) |-> ##[1:8] not_ready_output)
      else $error("secondary undervoltage not flagged");
   a_ext_fault_trip: assert property (!not_ready_output &&
      $fell(lower_external_fault_input_n) |-> ##[1:8] not_ready_output)
      else $error("external fault not flagged");
   a_off_when_nr: assert property (not_ready_output[*3] |-> !high_gate_on && !low_gate_on)
      else $error("gate on while not ready");
   a_halt_blocks: assert property (disable_request_input[*8] |-> !high_gate_on && !low_gate_on)
      else $error("gate on while halted");
   a_halt_no_nr: assert property (
      (!not_ready_output && no_fault)[*8] |=> !not_ready_output)
      else $error("not ready rose without fault");
   a_pulse_min: assert property ($rose(high_gate_on) |-> $past(high_side_command, 60))
      else $error("short command reached gate");
   a_recover_idle: assert property ($fell(not_ready_output) |-> idle_r >= 11'd1125)
      else $error("ready without idle time");
endmodule
bind gdfc_top gdfc_asserts chk_i (.*);

// ### testbench/gdfc_pwm_model.sv
// Behavioural PWM controller facing the gate driver primary pins
`timescale 1ns/100ps
module gdfc_pwm_model (
   // Clock, status from the driver and the external halt
   input logic mclk, not_ready_output, ext_halt,
   // Pins driven into the driver
   output logic high_side_command, low_side_command, disable_request_input
);
   // Not-ready looped into halt, other disables or-ed in
   assign disable_request_input = not_ready_output | ext_halt;
   // Commands idle low from time zero, so nothing switches in power-on reset
   initial begin
      high_side_command = 1'b0;
      low_side_command = 1'b0;
   end
   // One pulse of a cycle count on one side, changed only at rising edges
   task automatic pulse(input logic side, input int cycles);
      @(posedge mclk);
      if (side) high_side_command <= 1'b1;
      else low_side_command <= 1'b1;
      repeat (cycles) @(posedge mclk);
      high_side_command <= 1'b0;
      low_side_command <= 1'b0;
   endtask
endmodule

// ### testbench/tb_gate_driver_fault_control.sv
// Self-checking testbench for the gate driver fault control block
`timescale 1ns/100ps
module tb_gate_driver_fault_control;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ext_halt = 1'b0;
   logic [5:0] flt = 6'h00;  // Supply-good high from time zero and only dropped as a fault
   logic hs, ls, halt, hg, lg, nr;
   int err_total = 0;
   int num_checks = 0;
   // 125 MHz clock
   initial begin
      forever #4 mclk = ~mclk;
   end
   gdfc_pwm_model pwm (.mclk(mclk), .not_ready_output(nr), .ext_halt(ext_halt),
      .high_side_command(hs), .low_side_command(ls), .disable_request_input(halt));
   gdfc_top #(.POR_CYCLES(1200), .FAULT_CYCLES(2000)) DUT (.mclk(mclk), .rst(rst),
      .high_side_command(hs), .low_side_command(ls), .disable_request_input(halt),
      .supply_good_input(!flt[4]), .undervoltage_trip(flt[0]), .sec_undervoltage_trip(flt[1]),
      .short_circuit_detect(flt[2]), .upper_external_fault_input_n(!flt[3]),
      .lower_external_fault_input_n(!flt[5]), .high_gate_on(hg), .low_gate_on(lg),
      .not_ready_output(nr));
   task automatic chk(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Bounded wait for a not-ready level, counting cycles; a hang ends the run
   task automatic wait_nr(input logic lvl, output int n);
      n = 0;
      while (nr !== lvl) begin
         @(negedge mclk);
         n++;
         if (n > 4000) begin
            err_total++;
            finish_test();
         end
      end
   endtask
   task automatic t_por();
      int n;
      wait_nr(1'b0, n);
      chk("por length", 1'b1, n >= 1200);
      chk("ready", 1'b0, nr);
      $display("test por done");
   endtask
   task automatic t_filter();
      logic seen;
      seen = 1'b0;
      pwm.pulse(1'b1, 125);
      @(negedge mclk);
      chk("high gate on", 1'b1, hg);
      pwm.pulse(1'b0, 75);
      // Watch the whole window in which a passed short pulse would show
      repeat (200) begin
         @(negedge mclk);
         seen = seen | lg;
      end
      chk("short pulse", 1'b0, seen);
      chk("high gate off", 1'b0, hg);
      pwm.pulse(1'b0, 125);
      @(negedge mclk);
      chk("low gate on", 1'b1, lg);
      repeat (120) @(negedge mclk);
      $display("test filter done");
   endtask
   task automatic t_halt();
      @(posedge mclk);
      ext_halt <= 1'b1;
      pwm.pulse(1'b1, 125);
      @(negedge mclk);
      chk("halted gate", 1'b0, hg);
      chk("halt ready", 1'b0, nr);
      // Keep halt until the filtered command has dropped again
      repeat (120) @(posedge mclk);
      ext_halt <= 1'b0;
      repeat (20) @(negedge mclk);
      $display("test halt done");
   endtask
   // One fault source at a time; a pulse in the hold must be blocked
   task automatic t_fault(input int k);
      int n;
      @(posedge mclk);
      flt[k] <= 1'b1;
      repeat (10) @(negedge mclk);
      chk("trip", 1'b1, nr);
      pwm.pulse(1'b1, 125);
      flt[k] <= 1'b0;
      @(negedge mclk);
      chk("blocked", 1'b0, hg);
      wait_nr(1'b0, n);
      chk("hold time", 1'b1, n >= 1860);
      $display("test fault %0d done", k);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_por();
      t_filter();
      t_halt();
      for (int k = 0; k < 6; k++) t_fault(k);
      finish_test();
   end
endmodule
